// *** core/gpomx_pkg.sv ***
package gpomx_pkg;
    // register map: offset 0x12 is not a multiple of four, so it is an index
    localparam logic [7:0] CTL_INDEX = 8'h12;
    localparam logic [7:0] CTL_RESET = 8'h00;
    localparam logic [9:0] CTL_BYTE_ADDR = 10'h048; // index times four
    localparam int SEL_HI = 7;
    localparam int SEL_LO = 5;
    localparam int SRC_HI = 4;
    localparam int SRC_LO = 2;
    localparam int VAL_BIT = 1;
    localparam int EN_BIT = 0;
    // source group codes
    localparam logic [2:0] SRC_RX_MAX = 3'h3;
    localparam logic [2:0] SRC_STATUS = 3'h4;
    localparam logic [2:0] SRC_TX0 = 3'h6;
    localparam logic [2:0] SRC_TX1 = 3'h7;
    // select codes
    localparam logic [2:0] SEL_0 = 3'h0;
    localparam logic [2:0] SEL_1 = 3'h1;
    localparam logic [2:0] SEL_2 = 3'h2;
    localparam logic [2:0] SEL_3 = 3'h3;
    localparam logic [2:0] SEL_4 = 3'h4;
    localparam logic [2:0] SEL_5 = 3'h5;
    localparam logic [2:0] SEL_6 = 3'h6;
    localparam logic [2:0] SEL_7 = 3'h7;
    localparam int RX_PORTS = 4;
    localparam int TX_PORTS = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** core/gpomx_select.sv ***
`timescale 1ns/1ps
// combinational source and signal selection for the pin
module gpomx_select (
    input wire logic [7:0] ctl,
    input wire logic [15:0] rx_remote_pins,
    input wire logic [3:0] rx_lock,
    input wire logic [3:0] rx_pass,
    input wire logic [3:0] rx_enabled,
    input wire logic [3:0] rx_frame_valid,
    input wire logic [3:0] rx_line_valid,
    input wire logic frame_sync_pulse,
    input wire logic [7:0] tx_port_map,
    input wire logic [1:0] tx_frame_active,
    input wire logic [1:0] tx_line_active,
    input wire logic [1:0] tx_synced,
    input wire logic [1:0] tx_irq,
    output logic level
);
    logic [2:0] sel;
    logic [2:0] src;
    logic [1:0] rxi;
    logic txi;
    logic [3:0] tx_sel_mask;
    logic [3:0] lock_en;
    logic [3:0] pass_en;

    assign sel = ctl[gpomx_pkg::SEL_HI:gpomx_pkg::SEL_LO];
    assign src = ctl[gpomx_pkg::SRC_HI:gpomx_pkg::SRC_LO];
    assign rxi = src[1:0];
    assign txi = src[0];
    assign tx_sel_mask = txi ? tx_port_map[7:4] : tx_port_map[3:0];

    // disabled ports drop out of the device-wide combinations; the per-transmit ones ignore rx_enabled
    genvar g;
    generate
        for (g = 0; g < gpomx_pkg::RX_PORTS; g++) begin : g_rx
            assign lock_en[g] = rx_lock[g] | ~rx_enabled[g];
            assign pass_en[g] = rx_pass[g] | ~rx_enabled[g];
        end
    endgenerate

    // group then signal decode
    always_comb begin
        level = 1'b0;
        if (src <= gpomx_pkg::SRC_RX_MAX) begin
            case (sel)
                gpomx_pkg::SEL_0, gpomx_pkg::SEL_1, gpomx_pkg::SEL_2, gpomx_pkg::SEL_3:
                    level = rx_remote_pins[{rxi, sel[1:0]}];
                gpomx_pkg::SEL_4: level = rx_lock[rxi];
                gpomx_pkg::SEL_5: level = rx_pass[rxi];
                gpomx_pkg::SEL_6: level = rx_frame_valid[rxi];
                default: level = rx_line_valid[rxi];
            endcase
        end else if (src == gpomx_pkg::SRC_STATUS) begin
            case (sel)
                gpomx_pkg::SEL_0: level = ctl[gpomx_pkg::VAL_BIT];
                gpomx_pkg::SEL_1: level = |(rx_lock & rx_enabled);
                gpomx_pkg::SEL_2: level = (|rx_enabled) & (&lock_en);
                gpomx_pkg::SEL_3: level = (|rx_enabled) & (&pass_en);
                gpomx_pkg::SEL_4: level = frame_sync_pulse;
                default: level = 1'b0;
            endcase
        end else if (src == gpomx_pkg::SRC_TX0 || src == gpomx_pkg::SRC_TX1) begin
            case (sel)
                gpomx_pkg::SEL_0: level = (|tx_sel_mask) & (&(rx_pass | ~tx_sel_mask));
                gpomx_pkg::SEL_1: level = |(rx_pass & tx_sel_mask);
                gpomx_pkg::SEL_2: level = tx_frame_active[txi];
                gpomx_pkg::SEL_3: level = tx_line_active[txi];
                gpomx_pkg::SEL_4: level = tx_synced[txi];
                gpomx_pkg::SEL_5: level = tx_irq[txi];
                default: level = 1'b0;
            endcase
        end else begin
            level = 1'b0; // reserved group 101
        end
    end
endmodule // gpomx_select

// *** core/gpomx_top.sv ***
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
// Notes on behaviour
// - control register 0x12, 8 bits, reset zero
// - group: rx0-3, status, reserved, tx0, tx1
// - rx group codes 0-3: remote pins
// - rx group codes 4,5: lock, pass
// - rx group codes 6,7: frame, line valid
// - status code 0: software value bit
// - status codes 1,2: OR, AND of locks
// - status code 3: AND of passes
// - tx codes 0,1: AND, OR selected passes
// - tx codes 2,3: sending frame, line
// - bit 1 is the software pin level
// - bit 0 enables the pin driver
module gpomx_top (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic clk_en,
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [15:0] rx_remote_pins,
    input wire logic [3:0] rx_lock,
    input wire logic [3:0] rx_pass,
    input wire logic [3:0] rx_enabled,
    input wire logic [3:0] rx_frame_valid,
    input wire logic [3:0] rx_line_valid,
    input wire logic frame_sync_pulse,
    input wire logic [7:0] tx_port_map,
    input wire logic [1:0] tx_frame_active,
    input wire logic [1:0] tx_line_active,
    input wire logic [1:0] tx_synced,
    input wire logic [1:0] tx_irq,
    output logic pin_out,
    output logic pin_oe_n
);
    typedef enum logic [2:0] {
        WR_IDLE = 3'b001,
        WR_COLLECT = 3'b010,
        WR_RESP = 3'b100
    } gpomx_wr_state_type;

    gpomx_wr_state_type wr_state_reg, wr_state_next;
    logic aw_have_reg, aw_have_next;
    logic w_have_reg, w_have_next;
    logic [9:0] aw_addr_reg, aw_addr_next;
    logic [7:0] w_data_reg, w_data_next;
    logic w_strb_reg, w_strb_next;
    logic [1:0] bresp_reg, bresp_next;
    logic [7:0] ctl_reg, ctl_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic pin_out_reg, pin_out_next;
    logic pin_oe_n_reg, pin_oe_n_next;
    logic awready_reg, awready_next;
    logic wready_reg, wready_next;
    logic bvalid_reg, bvalid_next;
    logic arready_reg, arready_next;
    logic sel_level;
    logic aw_take, w_take;

    // bus handshake outputs come straight from their flip-flops
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign pin_out = pin_out_reg;
    assign pin_oe_n = pin_oe_n_reg;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;

    gpomx_select u_select (
        .ctl(ctl_reg),
        .rx_remote_pins(rx_remote_pins),
        .rx_lock(rx_lock),
        .rx_pass(rx_pass),
        .rx_enabled(rx_enabled),
        .rx_frame_valid(rx_frame_valid),
        .rx_line_valid(rx_line_valid),
        .frame_sync_pulse(frame_sync_pulse),
        .tx_port_map(tx_port_map),
        .tx_frame_active(tx_frame_active),
        .tx_line_active(tx_line_active),
        .tx_synced(tx_synced),
        .tx_irq(tx_irq),
        .level(sel_level)
    );

    // write channel: collect address and data in either order, then respond
    always_comb begin
        wr_state_next = wr_state_reg;
        aw_have_next = aw_have_reg;
        w_have_next = w_have_reg;
        aw_addr_next = aw_addr_reg;
        w_data_next = w_data_reg;
        w_strb_next = w_strb_reg;
        bresp_next = bresp_reg;
        ctl_next = ctl_reg;
        case (wr_state_reg)
            WR_IDLE, WR_COLLECT: begin
                if (aw_take) begin
                    aw_have_next = 1'b1;
                    aw_addr_next = s_axi_awaddr;
                end
                if (w_take) begin
                    w_have_next = 1'b1;
                    w_data_next = s_axi_wdata[7:0];
                    w_strb_next = s_axi_wstrb[0];
                end
                if (aw_have_next && w_have_next) begin
                    aw_have_next = 1'b0;
                    w_have_next = 1'b0;
                    wr_state_next = WR_RESP;
                    if (aw_addr_next[9:2] == gpomx_pkg::CTL_BYTE_ADDR[9:2]) begin
                        bresp_next = gpomx_pkg::RESP_OKAY;
                        if (w_strb_next) begin
                            ctl_next = w_data_next;
                        end
                    end else begin
                        bresp_next = gpomx_pkg::RESP_SLVERR;
                    end
                end else if (aw_have_next || w_have_next) begin
                    wr_state_next = WR_COLLECT;
                end
            end
            WR_RESP: begin
                if (s_axi_bready) begin
                    wr_state_next = WR_IDLE;
                end
            end
            default: wr_state_next = WR_IDLE;
        endcase
        // ready only while the matching half is still missing
        awready_next = (wr_state_next != WR_RESP) && !aw_have_next;
        wready_next = (wr_state_next != WR_RESP) && !w_have_next;
        bvalid_next = (wr_state_next == WR_RESP);
    end

    // read channel: one word, register in low byte, upper bits zero
    always_comb begin
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (rvalid_reg && s_axi_rready) begin
            rvalid_next = 1'b0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            if (s_axi_araddr[9:2] == gpomx_pkg::CTL_BYTE_ADDR[9:2]) begin
                rdata_next = {24'h000000, ctl_reg};
                rresp_next = gpomx_pkg::RESP_OKAY;
            end else begin
                rdata_next = 32'h00000000;
                rresp_next = gpomx_pkg::RESP_SLVERR;
            end
        end
        arready_next = !rvalid_next; // no new read while an answer stands
    end

    // pin driver: enable gates the selected level
    always_comb begin
        pin_oe_n_next = ~ctl_reg[gpomx_pkg::EN_BIT];
        pin_out_next = ctl_reg[gpomx_pkg::EN_BIT] & sel_level;
    end

    // state registers, frozen while clk_en is low
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_state_reg <= WR_IDLE;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_addr_reg <= 10'h000;
            w_data_reg <= 8'h00;
            w_strb_reg <= 1'b0;
            bresp_reg <= gpomx_pkg::RESP_OKAY;
            ctl_reg <= gpomx_pkg::CTL_RESET;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
            rresp_reg <= gpomx_pkg::RESP_OKAY;
            pin_out_reg <= 1'b0;
            pin_oe_n_reg <= 1'b1;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end else if (clk_en) begin
            wr_state_reg <= wr_state_next;
            aw_have_reg <= aw_have_next;
            w_have_reg <= w_have_next;
            aw_addr_reg <= aw_addr_next;
            w_data_reg <= w_data_next;
            w_strb_reg <= w_strb_next;
            bresp_reg <= bresp_next;
            ctl_reg <= ctl_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            pin_out_reg <= pin_out_next;
            pin_oe_n_reg <= pin_oe_n_next;
            awready_reg <= awready_next;
            wready_reg <= wready_next;
            bvalid_reg <= bvalid_next;
            arready_reg <= arready_next;
        end
    end

    // checks on register, decode and driver timing
    sequence s_soft_cfg;
        ctl_reg[gpomx_pkg::SRC_HI:gpomx_pkg::SRC_LO] == gpomx_pkg::SRC_STATUS
            && ctl_reg[gpomx_pkg::SEL_HI:gpomx_pkg::SEL_LO] == gpomx_pkg::SEL_0
            && ctl_reg[gpomx_pkg::EN_BIT];
    endsequence
    property p_reset_zero;
        @(posedge clk) $rose(arst_n) |-> ctl_reg == gpomx_pkg::CTL_RESET;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("control not zero");
    property p_disabled_float;
        @(posedge clk) disable iff (!arst_n)
            clk_en && !ctl_reg[gpomx_pkg::EN_BIT] |=> pin_oe_n && !pin_out;
    endproperty
    a_disabled_float: assert property (p_disabled_float) else $error("driven while off");
    property p_enabled_drive;
        @(posedge clk) disable iff (!arst_n)
            clk_en && ctl_reg[gpomx_pkg::EN_BIT] |=> !pin_oe_n;
    endproperty
    a_enabled_drive: assert property (p_enabled_drive) else $error("pin not driven");
    property p_soft_value;
        @(posedge clk) disable iff (!arst_n)
            clk_en and s_soft_cfg |=> pin_out == $past(ctl_reg[gpomx_pkg::VAL_BIT]);
    endproperty
    a_soft_value: assert property (p_soft_value) else $error("soft value not on pin");
    property p_follow_select;
        @(posedge clk) disable iff (!arst_n)
            clk_en && ctl_reg[gpomx_pkg::EN_BIT] |=> pin_out == $past(sel_level);
    endproperty
    a_follow_select: assert property (p_follow_select) else $error("pin off select");
    property p_reserved_low;
        @(posedge clk) disable iff (!arst_n)
            clk_en && ctl_reg[gpomx_pkg::SRC_HI:gpomx_pkg::SRC_LO] == 3'h5 |=> !pin_out;
    endproperty
    a_reserved_low: assert property (p_reserved_low) else $error("reserved drove high");
    property p_write_lands;
        @(posedge clk) disable iff (!arst_n)
            clk_en && wr_state_reg != WR_RESP && wr_state_next == WR_RESP
                && bresp_next == gpomx_pkg::RESP_OKAY && w_strb_next
            |=> ctl_reg == $past(w_data_next);
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("write lost");
    property p_read_back;
        @(posedge clk) disable iff (!arst_n)
            clk_en && s_axi_arvalid && s_axi_arready
                && s_axi_araddr[9:2] == gpomx_pkg::CTL_BYTE_ADDR[9:2]
            |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(ctl_reg) && s_axi_rdata[31:8] == 24'h0;
    endproperty
    a_read_back: assert property (p_read_back) else $error("read data mismatch");
    // clock enable low freezes the register and the pin
    property p_freeze;
        @(posedge clk) disable iff (!arst_n)
            !clk_en |=> $stable(ctl_reg) && $stable(pin_out) && $stable(pin_oe_n);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while frozen");
    // refused writes leave the register untouched
    sequence s_write_done;
        clk_en && wr_state_reg != WR_RESP && wr_state_next == WR_RESP;
    endsequence
    property p_keep_ctl;
        @(posedge clk) disable iff (!arst_n)
            s_write_done ##0 (bresp_next != gpomx_pkg::RESP_OKAY || !w_strb_next)
            |=> $stable(ctl_reg);
    endproperty
    a_keep_ctl: assert property (p_keep_ctl) else $error("refused write landed");
    // rx group lock selection reaches the pin one cycle later
    sequence s_rx_lock_cfg;
        !ctl_reg[gpomx_pkg::SRC_HI]
            && ctl_reg[gpomx_pkg::SEL_HI:gpomx_pkg::SEL_LO] == gpomx_pkg::SEL_4
            && ctl_reg[gpomx_pkg::EN_BIT];
    endsequence
    property p_rx_lock;
        @(posedge clk) disable iff (!arst_n)
            clk_en and s_rx_lock_cfg
            |=> pin_out == $past(rx_lock[ctl_reg[gpomx_pkg::SRC_LO+1:gpomx_pkg::SRC_LO]]);
    endproperty
    a_rx_lock: assert property (p_rx_lock) else $error("lock not on pin");
    // transmit group interrupt selection reaches the pin
    property p_tx_irq;
        @(posedge clk) disable iff (!arst_n)
            clk_en && ctl_reg[gpomx_pkg::SRC_HI:gpomx_pkg::SRC_LO+1] == gpomx_pkg::SRC_TX0[2:1]
                && ctl_reg[gpomx_pkg::SEL_HI:gpomx_pkg::SEL_LO] == gpomx_pkg::SEL_5
                && ctl_reg[gpomx_pkg::EN_BIT]
            |=> pin_out == $past(tx_irq[ctl_reg[gpomx_pkg::SRC_LO]]);
    endproperty
    a_tx_irq: assert property (p_tx_irq) else $error("interrupt not on pin");
endmodule // gpomx_top

// *** test/gpomx_tb.sv ***
`timescale 1ns/1ps
// self-checking bench for the pin source selector and its control register
module tb;
    logic clk = 1'h0;
    logic arst_n = 1'h0;
    logic clk_en = 1'h1;
    logic [9:0] s_axi_awaddr = 10'h000, s_axi_araddr = 10'h000;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic pin_out, pin_oe_n;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic [15:0] rx_remote_pins = 16'h0;
    logic [3:0] rx_lock = 4'h0, rx_pass = 4'h0, rx_enabled = 4'h0;
    logic [3:0] rx_frame_valid = 4'h0, rx_line_valid = 4'h0;
    logic frame_sync_pulse = 1'h0;
    logic [7:0] tx_port_map = 8'h00;
    logic [1:0] tx_frame_active = 2'h0, tx_line_active = 2'h0, tx_synced = 2'h0, tx_irq = 2'h0;
    logic [31:0] seed = 32'h533fba99;
    logic [31:0] rd;
    logic [1:0] rsp;
    logic [7:0] ctl_m = 8'h00; // model of the control register
    int miscompares = 0, n_compared = 0, cycles = 0;
    localparam logic [9:0] ADDR = gpomx_pkg::CTL_BYTE_ADDR;

    gpomx_top u_dut (.clk, .arst_n, .clk_en, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_remote_pins, .rx_lock, .rx_pass,
        .rx_enabled, .rx_frame_valid, .rx_line_valid, .frame_sync_pulse, .tx_port_map,
        .tx_frame_active, .tx_line_active, .tx_synced, .tx_irq, .pin_out, .pin_oe_n);

    // clock and watchdog
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end

    // random source: galois shift register
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {1'h0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
    endfunction

    // expected pin level from control value and current inputs
    function automatic logic model_pin(input logic [7:0] c);
        logic [2:0] s;
        logic [2:0] g;
        logic [3:0] m;
        logic t;
        s = c[7:5];
        g = c[4:2];
        t = g[0];
        m = t ? tx_port_map[7:4] : tx_port_map[3:0];
        if (c[0] == 1'h0) return 1'h0;
        if (g[2] == 1'h0) begin
            case (s)
                3'h4: return rx_lock[g[1:0]];
                3'h5: return rx_pass[g[1:0]];
                3'h6: return rx_frame_valid[g[1:0]];
                3'h7: return rx_line_valid[g[1:0]];
                default: return rx_remote_pins[{g[1:0], s[1:0]}];
            endcase
        end
        if (g == 3'h4) begin
            case (s)
                3'h0: return c[1];
                3'h1: return |(rx_lock & rx_enabled);
                3'h2: return rx_enabled != 4'h0 && (rx_lock & rx_enabled) == rx_enabled;
                3'h3: return rx_enabled != 4'h0 && (rx_pass & rx_enabled) == rx_enabled;
                3'h4: return frame_sync_pulse;
                default: return 1'h0;
            endcase
        end
        if (g == 3'h5) return 1'h0;
        case (s)
            3'h0: return m != 4'h0 && (rx_pass & m) == m;
            3'h1: return |(rx_pass & m);
            3'h2: return tx_frame_active[t];
            3'h3: return tx_line_active[t];
            3'h4: return tx_synced[t];
            3'h5: return tx_irq[t];
            default: return 1'h0;
        endcase
    endfunction

    // compare tasks, one per kind of result
    task cmp_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task cmp_pin(input string nm, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch %s expected %b seen %b", nm, e, g);
        end
    endtask

    // bus write: address and data offered together, response awaited
    task axi_write(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'h1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        forever begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid === 1'h1) begin
                rsp = s_axi_bresp;
                s_axi_bready <= 1'h0;
                break;
            end
        end
    endtask

    // bus read: data and response taken at the rvalid edge
    task axi_read(input logic [9:0] a);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        forever begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid === 1'h1) begin
                rd = s_axi_rdata;
                rsp = s_axi_rresp;
                s_axi_rready <= 1'h0;
                break;
            end
        end
    endtask

    // new random status inputs, then pin checked one cycle later
    task drive_inputs;
        logic [31:0] a, b;
        seed = lfsr(seed);
        a = seed;
        seed = lfsr(seed);
        b = seed;
        @(posedge clk);
        rx_remote_pins <= a[15:0];
        rx_lock <= a[19:16] | b[3:0];
        rx_pass <= a[19:16] | b[7:4];
        rx_enabled <= a[23:20];
        rx_frame_valid <= a[27:24];
        rx_line_valid <= a[31:28];
        frame_sync_pulse <= b[8];
        tx_port_map <= b[16:9];
        tx_frame_active <= b[18:17];
        tx_line_active <= b[20:19];
        tx_synced <= b[22:21];
        tx_irq <= b[24:23];
        @(posedge clk);
        #1;
        cmp_pin("pin_out", model_pin(ctl_m), pin_out);
        cmp_pin("pin_oe_n", ~ctl_m[0], pin_oe_n);
    endtask

    // register read back and response check
    task check_reg(input logic [9:0] a);
        axi_read(a);
        cmp_val("rdata", {24'h0, ctl_m}, rd);
        cmp_val("rresp", {30'h0, gpomx_pkg::RESP_OKAY}, {30'h0, rsp});
    endtask

    task end_of_test;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // main sequence: every control value, then strobes, unmapped space, reset
    initial begin
        repeat (10) @(posedge clk);
        arst_n <= 1'h1;
        check_reg(ADDR);
        #1;
        cmp_pin("pin_oe_n", 1'h1, pin_oe_n);
        for (int i = 0; i < 256; i++) begin
            seed = lfsr(seed);
            axi_write(ADDR, {seed[31:8], i[7:0]}, 4'hf);
            ctl_m = i[7:0];
            cmp_val("bresp", {30'h0, gpomx_pkg::RESP_OKAY}, {30'h0, rsp});
            check_reg(ADDR);
            repeat (4) drive_inputs();
        end
        axi_write(ADDR, 32'h0000_0000, 4'he);
        cmp_val("bresp", {30'h0, gpomx_pkg::RESP_OKAY}, {30'h0, rsp});
        check_reg(ADDR);
        axi_write(10'h04c, 32'h0000_0000, 4'hf);
        cmp_val("bresp", {30'h0, gpomx_pkg::RESP_SLVERR}, {30'h0, rsp});
        axi_read(10'h04c);
        cmp_val("rdata", 32'h0, rd);
        cmp_val("rresp", {30'h0, gpomx_pkg::RESP_SLVERR}, {30'h0, rsp});
        check_reg(10'h04b);
        drive_inputs();
        // freeze: with clk_en low the pin keeps its level while inputs move
        axi_write(ADDR, 32'h0000_0081, 4'hf);
        ctl_m = 8'h81;
        drive_inputs();
        @(posedge clk);
        clk_en <= 1'h0;
        rx_lock <= ~rx_lock;
        repeat (3) @(posedge clk);
        #1;
        cmp_pin("pin_out", ~model_pin(ctl_m), pin_out);
        @(posedge clk);
        clk_en <= 1'h1;
        @(posedge clk);
        #1;
        cmp_pin("pin_out", model_pin(ctl_m), pin_out);
        @(posedge clk);
        arst_n <= 1'h0;
        repeat (2) @(posedge clk);
        arst_n <= 1'h1;
        ctl_m = 8'h00;
        #1;
        cmp_pin("pin_oe_n", 1'h1, pin_oe_n);
        cmp_pin("pin_out", 1'h0, pin_out);
        check_reg(ADDR);
        end_of_test();
    end
endmodule // tb
